/* hw/ser_bank.sv */
// Status reporting register bank: three groups, standard event, status byte, trigger out
module ser_bank #(
	parameter int AXES = 4,
	parameter int LIMITS = 8
) (
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// Live instrument state, same clock
	input wire logic [15:0] ques_cond_in,
	input wire logic [15:0] oper_cond_in,
	input wire logic [AXES-1:0] axis_moving_in,
	input wire logic [LIMITS-1:0] limit_recovered_in,
	input wire logic [7:0] std_event_set_in,
	// Limit switch pins, asynchronous
	input wire logic [LIMITS-1:0] limit_pin_in,
	// Query port
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [3:0] sel_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	// Service request and trigger outputs
	output logic srq_out,
	output logic [AXES-1:0] trig_out
);

	logic [LIMITS-1:0] limit_meta;
	logic [LIMITS-1:0] limit_sync;
	logic [AXES-1:0] moving_q;
	logic [AXES-1:0] trig_en;
	logic [15:0] mot_cond_src;
	logic [15:0] mot_set;
	logic [15:0] ques_cond, ques_event, ques_enable;
	logic [15:0] oper_cond, oper_event, oper_enable;
	logic [15:0] mot_cond, mot_event, mot_enable;
	logic [7:0] std_cond, std_event, std_enable;
	logic ques_sum, oper_sum, mot_sum, std_sum;
	logic [7:0] srq_enable;
	logic [7:0] stb;
	logic [15:0] next_rdata;
	ser_pkg::ser_sel_t sel;

	// The motion register layout has room for exactly this many axes and switches
	if (AXES != ser_pkg::SER_AXES || LIMITS != ser_pkg::SER_LIMITS) begin : g_bad_size
		$error("ser_bank serves four axes and eight limit switches only");
	end

	assign sel = ser_pkg::ser_sel_t'(sel_in);

	////////////////////////////////////////////////////////////////////////////
	// Limit switches are pins, so two flops before use
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			limit_meta <= '0;
			limit_sync <= '0;
		end else if (ce_in) begin
			limit_meta <= limit_pin_in;
			limit_sync <= limit_meta;
		end
	end

	// Motion condition layout: axes at bits 1..4, limits at 8..15
	always_comb begin
		mot_cond_src = 16'h0000;
		mot_cond_src[ser_pkg::SER_MOT_AXIS_LSB +: AXES] = axis_moving_in;
		mot_cond_src[ser_pkg::SER_MOT_LIMIT_LSB +: LIMITS] = limit_sync;
		mot_set = 16'h0000;
		mot_set[ser_pkg::SER_MOT_LIMIT_LSB +: LIMITS] = limit_recovered_in;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register groups; event registers clear on their own read
	ser_group #(.W(16), .CHG_MASK(16'hffff)) u_ques (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.cond_in(ques_cond_in), .set_in(16'h0000),
		.clr_in(rd_in && sel == ser_pkg::SER_SEL_QUES_EVENT),
		.en_wr_in(wr_in && sel == ser_pkg::SER_SEL_QUES_ENABLE), .en_data_in(wdata_in),
		.cond_out(ques_cond), .event_out(ques_event), .enable_out(ques_enable),
		.summary_out(ques_sum)
	);

	ser_group #(.W(16), .CHG_MASK(16'hffff)) u_oper (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.cond_in(oper_cond_in), .set_in(16'h0000),
		.clr_in(rd_in && sel == ser_pkg::SER_SEL_OPER_EVENT),
		.en_wr_in(wr_in && sel == ser_pkg::SER_SEL_OPER_ENABLE), .en_data_in(wdata_in),
		.cond_out(oper_cond), .event_out(oper_event), .enable_out(oper_enable),
		.summary_out(oper_sum)
	);

	// Axis bits latch on change; limit bits only on recovery, not on every bounce
	ser_group #(.W(16), .CHG_MASK(ser_pkg::SER_MOT_CHG_MASK)) u_mot (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.cond_in(mot_cond_src), .set_in(mot_set),
		.clr_in(rd_in && sel == ser_pkg::SER_SEL_MOT_EVENT),
		.en_wr_in(wr_in && sel == ser_pkg::SER_SEL_MOT_ENABLE), .en_data_in(wdata_in),
		.cond_out(mot_cond), .event_out(mot_event), .enable_out(mot_enable),
		.summary_out(mot_sum)
	);

	// Standard event register has no condition layer
	ser_group #(.W(8), .CHG_MASK(8'h00)) u_std (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.cond_in(8'h00), .set_in(std_event_set_in),
		.clr_in(rd_in && sel == ser_pkg::SER_SEL_STD_EVENT),
		.en_wr_in(wr_in && sel == ser_pkg::SER_SEL_STD_ENABLE),
		.en_data_in(wdata_in[7:0]),
		.cond_out(std_cond), .event_out(std_event), .enable_out(std_enable),
		.summary_out(std_sum)
	);

	////////////////////////////////////////////////////////////////////////////
	// Service request enable, bit 6 is always held at zero
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			srq_enable <= ser_pkg::SER_BYTE_RST;
		end else if (ce_in && wr_in && sel == ser_pkg::SER_SEL_SRQ_ENABLE) begin
			srq_enable <= wdata_in[7:0] & 8'hbf;
		end
	end

	// Status byte is built live from the group summaries
	always_comb begin
		stb = 8'h00;
		stb[ser_pkg::SER_STB_MOT] = mot_sum;
		stb[ser_pkg::SER_STB_QUES] = ques_sum;
		stb[ser_pkg::SER_STB_ESB] = std_sum;
		stb[ser_pkg::SER_STB_OPER] = oper_sum;
		stb[ser_pkg::SER_STB_RQS] = |(stb & srq_enable);
	end

	assign srq_out = stb[ser_pkg::SER_STB_RQS];

	////////////////////////////////////////////////////////////////////////////
	// Trigger enable mask, one bit per axis
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			trig_en <= ser_pkg::SER_TRIG_RST;
		end else if (ce_in && wr_in && sel == ser_pkg::SER_SEL_TRIG_ENABLE) begin
			trig_en <= wdata_in[AXES-1:0];
		end
	end

	// Trajectory end raises the output; a new move drops it again
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			moving_q <= '0;
			trig_out <= '0;
		end else if (ce_in) begin
			moving_q <= axis_moving_in;
			trig_out <= trig_en & (trig_out | (moving_q & ~axis_moving_in))
				& ~axis_moving_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; zero on unused codes
	always_comb begin
		next_rdata = 16'h0000;
		unique case (sel)
			ser_pkg::SER_SEL_QUES_COND: next_rdata = ques_cond;
			ser_pkg::SER_SEL_QUES_EVENT: next_rdata = ques_event;
			ser_pkg::SER_SEL_QUES_ENABLE: next_rdata = ques_enable;
			ser_pkg::SER_SEL_OPER_COND: next_rdata = oper_cond;
			ser_pkg::SER_SEL_OPER_EVENT: next_rdata = oper_event;
			ser_pkg::SER_SEL_OPER_ENABLE: next_rdata = oper_enable;
			ser_pkg::SER_SEL_MOT_COND: next_rdata = mot_cond;
			ser_pkg::SER_SEL_MOT_EVENT: next_rdata = mot_event;
			ser_pkg::SER_SEL_MOT_ENABLE: next_rdata = mot_enable;
			ser_pkg::SER_SEL_STD_EVENT: next_rdata = {8'h00, std_event};
			ser_pkg::SER_SEL_STD_ENABLE: next_rdata = {8'h00, std_enable};
			ser_pkg::SER_SEL_STATUS_BYTE: next_rdata = {8'h00, stb};
			ser_pkg::SER_SEL_SRQ_ENABLE: next_rdata = {8'h00, srq_enable};
			ser_pkg::SER_SEL_TRIG_ENABLE: next_rdata = {12'h000, trig_en};
			default: next_rdata = 16'h0000;
		endcase
	end

	// Data is taken before the clear at the same edge
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 16'h0000;
			rvalid_out <= 1'b0;
		end else if (ce_in) begin
			rvalid_out <= rd_in;
			if (rd_in) begin
				rdata_out <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output checks; the pin path needs four enabled edges, one for the pin and three flops
	a_axis1_moving: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in |=> mot_cond[1] == $past(axis_moving_in[0]))
		else $error("motion bit 1 does not follow axis 1");
	a_limit_sync: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in [*4] |-> mot_cond[15:8] == $past(limit_pin_in, 3))
		else $error("limit bits do not follow pins after sync");
	a_axis1_event: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && (mot_cond_src[1] != mot_cond[1]) |=> mot_event[1])
		else $error("axis 1 change not latched");
	a_recov_event: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && limit_recovered_in[0] |=> mot_event[8])
		else $error("recovery not latched");
	a_read_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && rd_in && sel == ser_pkg::SER_SEL_MOT_EVENT && mot_set == 16'h0000
		&& mot_cond_src == mot_cond |=> mot_event == 16'h0000 && rdata_out == $past(mot_event))
		else $error("motion event read did not return then clear");
	a_trig_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && trig_en[0] && moving_q[0] && !axis_moving_in[0] |=> trig_out[0]
		&& !mot_cond[1])
		else $error("trajectory end did not raise trigger");
	a_trig_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && (!trig_en[0] || axis_moving_in[0]) |=> !trig_out[0])
		else $error("trigger high while disabled or moving");
	a_srq_mask: assert property (@(posedge clk_in) disable iff (!resetn_in)
		srq_out |-> (stb & srq_enable & 8'hbf) != 8'h00)
		else $error("service request without enabled summary");
	a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && rd_in |=> rvalid_out)
		else $error("read answer missing");

endmodule

/* pkg/ser_pkg.sv */
// Constants and types shared by the status and event register bank
package ser_pkg;

	// Register select codes on the query port
	typedef enum logic [3:0] {
		SER_SEL_QUES_COND = 4'h0,
		SER_SEL_QUES_EVENT = 4'h1,
		SER_SEL_QUES_ENABLE = 4'h2,
		SER_SEL_OPER_COND = 4'h3,
		SER_SEL_OPER_EVENT = 4'h4,
		SER_SEL_OPER_ENABLE = 4'h5,
		SER_SEL_MOT_COND = 4'h6,
		SER_SEL_MOT_EVENT = 4'h7,
		SER_SEL_MOT_ENABLE = 4'h8,
		SER_SEL_STD_EVENT = 4'h9,
		SER_SEL_STD_ENABLE = 4'ha,
		SER_SEL_STATUS_BYTE = 4'hb,
		SER_SEL_SRQ_ENABLE = 4'hc,
		SER_SEL_TRIG_ENABLE = 4'hd
	} ser_sel_t;

	localparam int SER_GROUP_W = 16;
	localparam int SER_BYTE_W = 8;
	localparam int SER_AXES = 4;
	localparam int SER_LIMITS = 8;

	// Field positions
	localparam int SER_MOT_AXIS_LSB = 1;
	localparam int SER_MOT_LIMIT_LSB = 8;
	localparam int SER_STB_MOT = 0;
	localparam int SER_STB_QUES = 3;
	localparam int SER_STB_ESB = 5;
	localparam int SER_STB_RQS = 6;
	localparam int SER_STB_OPER = 7;

	// Values after reset
	localparam logic [15:0] SER_GROUP_RST = 16'h0000;
	localparam logic [7:0] SER_BYTE_RST = 8'h00;
	localparam logic [3:0] SER_TRIG_RST = 4'h0;

	// Which motion bits latch on a change of condition
	localparam logic [15:0] SER_MOT_CHG_MASK = 16'h001e;

endpackage

/* hw/ser_group.sv */
// One condition / event / enable register group with read-to-clear events
module ser_group #(
	parameter int W = 16,
	parameter logic [W-1:0] CHG_MASK = '1
) (
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// Event sources
	input wire logic [W-1:0] cond_in,
	input wire logic [W-1:0] set_in,
	// Software side
	input wire logic clr_in,
	input wire logic en_wr_in,
	input wire logic [W-1:0] en_data_in,
	// Register contents
	output logic [W-1:0] cond_out,
	output logic [W-1:0] event_out,
	output logic [W-1:0] enable_out,
	output logic summary_out
);

	logic [W-1:0] next_set;

	// Widths beyond one register word are refused at elaboration
	if (W < 1 || W > 16) begin : g_bad_width
		$error("ser_group width out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Condition follows its source, one cycle late
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cond_out <= '0;
		end else if (ce_in) begin
			cond_out <= cond_in;
		end
	end

	// Edge of any masked bit plus direct set pulses
	assign next_set = ((cond_in ^ cond_out) & CHG_MASK) | set_in;

	// Set wins over the read clear, so no edge is lost at the read
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			event_out <= '0;
		end else if (ce_in) begin
			event_out <= (clr_in ? '0 : event_out) | next_set;
		end
	end

	// Enable mask, software written
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			enable_out <= '0;
		end else if (ce_in && en_wr_in) begin
			enable_out <= en_data_in;
		end
	end

	assign summary_out = |(event_out & enable_out);

	////////////////////////////////////////////////////////////////////////////
	// Event latch checks; frozen cycles are left out
	a_set_wins_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && clr_in |=> event_out == $past(next_set))
		else $error("event clear did not keep simultaneous set");
	a_change_latched: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in |=> (event_out & $past(next_set)) == $past(next_set))
		else $error("condition change not latched");
	a_hold_no_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !clr_in |=> (event_out & $past(event_out)) == $past(event_out))
		else $error("event bit lost without read");

endmodule

/* bench/ser_host.sv */
// Host-side model that issues register queries and writes on the query port
module ser_host (
	// Clock
	input wire logic clk_in,
	// Query port requests
	output logic rd_out,
	output logic wr_out,
	output logic [3:0] sel_out,
	output logic [15:0] wdata_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle at time zero
	initial begin
		rd_out = 1'b0;
		wr_out = 1'b0;
		sel_out = 4'h0;
		wdata_out = 16'h0000;
	end

	// One read request, held for exactly one taking edge
	task automatic read_reg(input logic [3:0] s);
		@(posedge clk_in);
		rd_out <= 1'b1;
		sel_out <= s;
		@(posedge clk_in);
		rd_out <= 1'b0;
		sel_out <= ~s; // Released select no longer shows the old code
	endtask

	// One write request; no answer comes back
	task automatic write_reg(input logic [3:0] s, input logic [15:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		sel_out <= s;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		sel_out <= ~s;
		wdata_out <= ~d;
	endtask
endmodule

/* bench/ser_bank_bench.sv */
// Self-checking bench for the status and event register bank
module ser_bank_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [15:0] ques_cond_in = 16'h0000;
	logic [15:0] oper_cond_in = 16'h0000;
	logic [3:0] axis_moving_in = 4'h0;
	logic [7:0] limit_recovered_in = 8'h00;
	logic [7:0] std_event_set_in = 8'h00;
	logic [7:0] limit_pin_in = 8'h00;
	logic ce_in = 1'b1;
	logic rd_in, wr_in, rvalid_out, srq_out;
	logic [3:0] sel_in, trig_out;
	logic [15:0] wdata_in, rdata_out;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h8f470515;
	logic [15:0] q, o, e;
	logic [7:0] r;
	int fail_count = 0;
	int checks = 0;

	// 125 MHz clock
	always #4 clk_in = ~clk_in;

	ser_bank u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.ques_cond_in(ques_cond_in), .oper_cond_in(oper_cond_in),
		.axis_moving_in(axis_moving_in), .limit_recovered_in(limit_recovered_in),
		.std_event_set_in(std_event_set_in), .limit_pin_in(limit_pin_in),
		.rd_in(rd_in), .wr_in(wr_in), .sel_in(sel_in), .wdata_in(wdata_in),
		.rdata_out(rdata_out), .rvalid_out(rvalid_out), .srq_out(srq_out), .trig_out(trig_out));

	ser_host u_host (.clk_in(clk_in), .rd_out(rd_in), .wr_out(wr_in), .sel_out(sel_in),
		.wdata_out(wdata_in));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// Note the expected answer, then let the host ask
	task automatic rd_chk(input logic [3:0] s, input logic [15:0] x);
		exp_q.push_back(x);
		u_host.read_reg(s);
	endtask

	task automatic cmp_read(input logic [15:0] got, input logic [15:0] x);
		checks++;
		if (got !== x) begin
			fail_count++;
			$display("mismatch at %0t: read %h expected %h", $time, got, x);
		end
	endtask

	task automatic cmp_pin(input logic [3:0] got, input logic [3:0] x);
		checks++;
		if (got !== x) begin
			fail_count++;
			$display("mismatch at %0t: pin %h expected %h", $time, got, x);
		end
	endtask

	task automatic conclude();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: each answer pulse is checked against the oldest note
	always @(negedge clk_in) begin
		if (rvalid_out === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("mismatch at %0t: unexpected answer", $time);
			end else begin
				cmp_read(rdata_out, exp_q.pop_front());
			end
		end
	end

	// Watchdog sized well above the expected run length
	initial begin
		#(8 * 20000);
		fail_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(8);
		resetn_in <= 1'b1;
		// Every register, including unused codes, reads zero after reset
		for (int s = 0; s < 16; s++) begin
			rd_chk(s[3:0], 16'h0000);
		end
		// Axis 1 starts, then stops: condition follows, event latches and clears on read
		axis_moving_in <= 4'h1;
		tick(3);
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'h0002);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0002);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0000);
		axis_moving_in <= 4'h0;
		tick(3);
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'h0000);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0002);
		// Standard event, status byte and request enable with a forced-low bit 6
		r = 8'(xs()) | 8'h01;
		std_event_set_in <= r;
		tick(1);
		std_event_set_in <= 8'h00;
		u_host.write_reg(ser_pkg::SER_SEL_STD_ENABLE, 16'h00ff);
		u_host.write_reg(ser_pkg::SER_SEL_SRQ_ENABLE, 16'h0060);
		tick(2);
		cmp_pin({3'h0, srq_out}, 4'h1);
		rd_chk(ser_pkg::SER_SEL_SRQ_ENABLE, 16'h0020);
		rd_chk(ser_pkg::SER_SEL_STATUS_BYTE, 16'h0060);
		rd_chk(ser_pkg::SER_SEL_STD_EVENT, {8'h00, r});
		rd_chk(ser_pkg::SER_SEL_STATUS_BYTE, 16'h0000);
		// Questionable and operation groups; condition codes ignore writes
		q = 16'(xs());
		o = 16'(xs());
		e = 16'(xs());
		ques_cond_in <= q;
		oper_cond_in <= o;
		tick(3);
		u_host.write_reg(ser_pkg::SER_SEL_QUES_COND, ~q);
		u_host.write_reg(ser_pkg::SER_SEL_OPER_ENABLE, e);
		u_host.write_reg(ser_pkg::SER_SEL_QUES_ENABLE, 16'hffff);
		rd_chk(ser_pkg::SER_SEL_QUES_ENABLE, 16'hffff);
		// Summaries land at bit 3 (questionable) and bit 7 (operation) of the status byte
		rd_chk(ser_pkg::SER_SEL_STATUS_BYTE, {8'h00, |(o & e), 3'b000, |q, 3'b000});
		rd_chk(ser_pkg::SER_SEL_QUES_COND, q);
		rd_chk(ser_pkg::SER_SEL_QUES_EVENT, q);
		rd_chk(ser_pkg::SER_SEL_OPER_COND, o);
		rd_chk(ser_pkg::SER_SEL_OPER_EVENT, o);
		rd_chk(ser_pkg::SER_SEL_OPER_ENABLE, e);
		rd_chk(ser_pkg::SER_SEL_OPER_EVENT, 16'h0000);
		// Limit pins show in condition only; recovery pulses latch events
		limit_pin_in <= 8'ha5;
		tick(5);
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'ha500);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0000);
		limit_recovered_in <= 8'h3c;
		tick(1);
		limit_recovered_in <= 8'h00;
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h3c00);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0000);
		// Trigger output on axis 1 only, at end of its trajectory
		u_host.write_reg(ser_pkg::SER_SEL_TRIG_ENABLE, 16'h0001);
		rd_chk(ser_pkg::SER_SEL_TRIG_ENABLE, 16'h0001);
		axis_moving_in <= 4'h3;
		tick(3);
		cmp_pin(trig_out, 4'h0);
		axis_moving_in <= 4'h0;
		tick(3);
		cmp_pin(trig_out, 4'h1);
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'ha500);
		axis_moving_in <= 4'h1;
		tick(3);
		cmp_pin(trig_out, 4'h0);
		// Motion summary at bit 0 raises a service request until the event is read
		u_host.write_reg(ser_pkg::SER_SEL_MOT_ENABLE, 16'h0004);
		rd_chk(ser_pkg::SER_SEL_STATUS_BYTE, 16'h0001);
		u_host.write_reg(ser_pkg::SER_SEL_SRQ_ENABLE, 16'h0001);
		tick(1);
		cmp_pin({3'h0, srq_out}, 4'h1);
		rd_chk(ser_pkg::SER_SEL_MOT_EVENT, 16'h0006);
		tick(1);
		cmp_pin({3'h0, srq_out}, 4'h0);
		// Enable low freezes all: the read gets no answer and the pins wait in the synchroniser
		tick(1);
		ce_in <= 1'b0;
		limit_pin_in <= 8'h5a;
		u_host.read_reg(ser_pkg::SER_SEL_MOT_COND);
		ce_in <= 1'b1;
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'ha502);
		rd_chk(ser_pkg::SER_SEL_MOT_COND, 16'h5a02);
		tick(4);
		cmp_pin(exp_q.size() == 0 ? 4'h0 : 4'hf, 4'h0);
		conclude();
	end
endmodule
